// File: rtl/prs_cfg.svh
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
// register byte offsets
`define PRS_ADDR_CTRL   6'h00
`define PRS_ADDR_NUMER  6'h04
`define PRS_ADDR_DENOM  6'h08
`define PRS_ADDR_REF    6'h0c
`define PRS_ADDR_ACT    6'h10
`define PRS_ADDR_MEND   6'h14
`define PRS_ADDR_UPLIM  6'h18
`define PRS_ADDR_LOLIM  6'h1c
`define PRS_ADDR_TGT    6'h20
`define PRS_ADDR_STEPS  6'h24
`define PRS_ADDR_STAT   6'h28
`define PRS_ADDR_MASK   6'h2c
// control bits
`define PRS_CTRL_DIR     0
`define PRS_CTRL_RESTORE 1
// event bits of status and mask
`define PRS_EV_MEND_REJ  0
`define PRS_EV_TGT_REJ   1
`define PRS_EV_SCL_REJ   2
`define PRS_EV_LIM_REJ   3
`define PRS_EV_TGT_OK    4
`define PRS_EV_W         5
// scaling and range
`define PRS_SCALE_DEF   14'h0190
`define PRS_SCALE_MIN   32'h00000001
`define PRS_SCALE_MAX   32'h00002710
`define PRS_STEPS_ROT   32'sh00000190
`define PRS_MARGIN_ROT  32'sh00000003
`define PRS_LOW_ROT     32'sh000000fd
`define PRS_MEAS_ROT    32'sh00000100
`define PRS_OFF_DEF     32'sh00000000
`define PRS_ROUND_TOL   32'sh00000001
`define PRS_MARGIN_STEPS (`PRS_STEPS_ROT * `PRS_MARGIN_ROT)
`define PRS_SPAN_STEPS   (`PRS_STEPS_ROT * `PRS_LOW_ROT)
`define PRS_MEND_DEF     (`PRS_STEPS_ROT * `PRS_MEAS_ROT)
`define PRS_BE_FULL     4'hf
`endif

// File: rtl/prs_pkg.sv
// Purpose: types shared by the position range scaling block
// Assumes: constants come from prs_cfg.svh
// Notes:   gray codes along idle, run, done
package prs_pkg;
  typedef enum logic [1:0]
  {
    prs_st_idle = 2'h0,
    prs_st_run  = 2'h1,
    prs_st_done = 2'h3
  } prs_state_t;

  typedef enum logic [3:0]
  {
    prs_op_rd     = 4'h0,
    prs_op_off    = 4'h1,
    prs_op_setact = 4'h2,
    prs_op_me1    = 4'h3,
    prs_op_me2    = 4'h4,
    prs_op_up     = 4'h5,
    prs_op_lo     = 4'h6,
    prs_op_tgt    = 4'h7,
    prs_op_sc1    = 4'h8,
    prs_op_sc2    = 4'h9,
    prs_op_sc3    = 4'ha
  } prs_op_t;
endpackage

// File: rtl/prs_div.sv
// Purpose: round(x * mul / den), nearest, halves away from zero
// Assumes: den is never zero; start only while idle
// Notes:   one quotient bit per cycle, XW+MW+1 cycles
`timescale 1ns/100ps
module prs_div
#(
  parameter int XW = 32,
  parameter int MW = 14
)(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 start,
  input  wire logic signed [XW-1:0] x,
  input  wire logic        [MW-1:0] mul,
  input  wire logic        [MW-1:0] den,
  output logic                      done_q,
  output logic signed [XW+MW:0]     quot_q
);
  localparam int PW = XW + MW + 1;
  localparam int CW = $clog2(PW + 1);

  logic        [PW-1:0] num_q, num_d;
  logic        [MW-1:0] rem_q, rem_d;
  logic        [MW-1:0] den_q, den_d;
  logic                 neg_q, neg_d;
  logic                 run_q, run_d;
  logic        [CW-1:0] cnt_q, cnt_d;
  logic                 done_d;
  logic signed [PW-1:0] quot_d;
  logic signed [PW-1:0] prod;
  logic        [MW:0]   trial;

  always_comb
  begin
    num_d  = num_q;
    rem_d  = rem_q;
    den_d  = den_q;
    neg_d  = neg_q;
    run_d  = run_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    quot_d = quot_q;
    prod   = PW'(x) * PW'($signed({1'b0, mul}));
    trial  = {rem_q, num_q[PW-1]};
    if (start)
    begin
      // bias by half the divisor so truncation rounds to nearest
      num_d = (prod[PW-1] ? PW'(-prod) : PW'(prod)) + PW'(den >> 1);
      rem_d = '0;
      den_d = den;
      neg_d = prod[PW-1];
      run_d = 1'b1;
      cnt_d = CW'(PW);
    end
    else if (run_q)
    begin
      if (trial >= {1'b0, den_q})
      begin
        rem_d = MW'(trial - {1'b0, den_q});
        num_d = {num_q[PW-2:0], 1'b1};
      end
      else
      begin
        rem_d = trial[MW-1:0];
        num_d = {num_q[PW-2:0], 1'b0};
      end
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == CW'(1))
      begin
        run_d  = 1'b0;
        done_d = 1'b1;
        quot_d = neg_q ? -$signed(num_d) : $signed(num_d);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      num_q  <= '0;
      rem_q  <= '0;
      den_q  <= '0;
      neg_q  <= 1'b0;
      run_q  <= 1'b0;
      cnt_q  <= '0;
      done_q <= 1'b0;
      quot_q <= '0;
    end
    else
    begin
      num_q  <= num_d;
      rem_q  <= rem_d;
      den_q  <= den_d;
      neg_q  <= neg_d;
      run_q  <= run_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      quot_q <= quot_d;
    end
  end
endmodule

// File: rtl/prs_irq.sv
// Purpose: sticky event status, mask and level interrupt
// Assumes: events are one-cycle pulses
// Notes:   write one to clear; a new event wins over its clear
`timescale 1ns/100ps
module prs_irq
#(
  parameter int W = 5
)(
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] ev,
  input  wire logic         clr_we,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] stat_q,
  output logic      [W-1:0] mask_q,
  output logic              irq_q
);
  logic [W-1:0] stat_d, mask_d;
  logic         irq_d;

  always_comb
  begin
    stat_d = (stat_q & ~(clr_we ? wdata : '0)) | ev;
    mask_d = mask_we ? wdata : mask_q;
    irq_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end
endmodule

// File: rtl/prs_top.sv
// Purpose: position scaling, referencing and range placement
// Assumes: enc_steps is on core_clk, 400 steps per shaft rotation
// Notes:   positions stored in encoder steps; user units made on access
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "prs_cfg.svh"
module prs_top
  import prs_pkg::*;
#(
  parameter int PW = 32,
  parameter int SW = 14
)(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic signed [PW-1:0] enc_steps,
  output logic signed [PW-1:0]      tgt_steps,
  output logic                      tgt_go,
  output logic                      irq
);
  localparam logic signed [PW-1:0] MARGIN = PW'(`PRS_MARGIN_STEPS);
  localparam logic signed [PW-1:0] SPAN   = PW'(`PRS_SPAN_STEPS);
  localparam logic signed [PW-1:0] MEND0  = PW'(`PRS_MEND_DEF);
  localparam logic signed [PW-1:0] STEPS  = PW'(`PRS_STEPS_ROT);
  localparam logic signed [PW-1:0] OFF0   = PW'(`PRS_OFF_DEF);
  localparam logic signed [PW-1:0] TOL    = PW'(`PRS_ROUND_TOL);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  prs_state_t              st_q, st_d;
  prs_op_t                 op_q, op_d;
  logic        [31:0]      rdata_q, rdata_d;
  logic                    wait_q, wait_d;
  logic signed [PW-1:0]    wdat_q, wdat_d;
  logic                    dir_q, dir_d;
  logic        [SW-1:0]    numer_q, numer_d, denom_q, denom_d;
  logic signed [PW-1:0]    off_q, off_d, me_q, me_d, lo_q, lo_d, hi_q, hi_d;
  logic signed [PW-1:0]    tgt_q, tgt_d, act_q, act_d;
  logic signed [PW-1:0]    qs_q, qs_d, qb_q, qb_d, spr_q, spr_d;
  logic                    go_q, go_d;
  logic                    div_start, div_done;
  logic signed [PW-1:0]    div_x, q, rel, a_pos;
  logic        [SW-1:0]    div_m, div_n;
  logic signed [PW+SW:0]   div_q;
  logic [`PRS_EV_W-1:0]    ev, stat, mask;
  logic                    clr_we, mask_we, restore_now, me_ok;

  function automatic logic scale_ok(input logic [31:0] v);
    scale_ok = (v >= `PRS_SCALE_MIN) && (v <= `PRS_SCALE_MAX);
  endfunction

  function automatic logic in_rng(input logic signed [PW-1:0] v, lo, hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  assign a_pos = dir_q ? -enc_steps : enc_steps;
  assign q     = div_q[PW-1:0];
  assign rel   = q - off_q;

  // ----------------------------------------------------------------
  // bus and sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;  op_d = op_q;  rdata_d = rdata_q;  wdat_d = wdat_q;
    dir_d = dir_q;  numer_d = numer_q;  denom_d = denom_q;
    off_d = off_q;  me_d = me_q;  lo_d = lo_q;  hi_d = hi_q;
    tgt_d = tgt_q;  act_d = act_q;  qs_d = qs_q;  qb_d = qb_q;  spr_d = spr_q;
    go_d = 1'b0;  div_start = 1'b0;  div_x = '0;
    // user values always derive from the current factors
    div_m = denom_q;  div_n = numer_q;
    ev = '0;  clr_we = 1'b0;  mask_we = 1'b0;  restore_now = 1'b0;  me_ok = 1'b0;
    case (st_q)
      prs_st_idle:
      begin
        if (avs_read || avs_write)
        begin
          st_d   = prs_st_done;
          wdat_d = $signed(avs_writedata);
          if (avs_read)
          begin
            rdata_d = '0;
            case (avs_address)
              `PRS_ADDR_CTRL:  rdata_d[`PRS_CTRL_DIR] = dir_q;
              `PRS_ADDR_NUMER: rdata_d = 32'(numer_q);
              `PRS_ADDR_DENOM: rdata_d = 32'(denom_q);
              `PRS_ADDR_STEPS: rdata_d = 32'(spr_q);
              `PRS_ADDR_STAT:  rdata_d = 32'(stat);
              `PRS_ADDR_MASK:  rdata_d = 32'(mask);
              `PRS_ADDR_REF, `PRS_ADDR_ACT, `PRS_ADDR_MEND,
              `PRS_ADDR_UPLIM, `PRS_ADDR_LOLIM, `PRS_ADDR_TGT:
              begin
                st_d = prs_st_run;
                op_d = prs_op_rd;
                div_start = 1'b1;
                // one offset shifts every value alike
                case (avs_address)
                  `PRS_ADDR_REF:   div_x = off_q;
                  `PRS_ADDR_ACT:   div_x = a_pos + off_q;
                  `PRS_ADDR_MEND:  div_x = me_q + off_q;
                  `PRS_ADDR_UPLIM: div_x = hi_q + off_q;
                  `PRS_ADDR_LOLIM: div_x = lo_q + off_q;
                  default:         div_x = tgt_q + off_q;
                endcase
              end
              default: ;
            endcase
          end
          else if (avs_byteenable == `PRS_BE_FULL)
          begin
            div_m = numer_q;
            div_n = denom_q;
            div_x = $signed(avs_writedata);
            case (avs_address)
              `PRS_ADDR_CTRL:
              begin
                // a new direction drops the placement back to its defaults
                if (avs_writedata[`PRS_CTRL_DIR] != dir_q)
                begin
                  dir_d = avs_writedata[`PRS_CTRL_DIR];
                  off_d = OFF0;  me_d = MEND0;  lo_d = MEND0 - SPAN;  hi_d = MEND0 - MARGIN;
                end
                if (avs_writedata[`PRS_CTRL_RESTORE])
                begin
                  restore_now = 1'b1;
                  dir_d = 1'b0;  numer_d = `PRS_SCALE_DEF;  denom_d = `PRS_SCALE_DEF;
                  off_d = OFF0;  me_d = MEND0;  lo_d = MEND0 - SPAN;  hi_d = MEND0 - MARGIN;
                  qs_d = MARGIN;  qb_d = SPAN;  spr_d = STEPS;
                end
              end
              `PRS_ADDR_NUMER, `PRS_ADDR_DENOM:
              begin
                if (scale_ok(avs_writedata))
                begin
                  if (avs_address == `PRS_ADDR_NUMER)
                    numer_d = SW'(avs_writedata);
                  else
                    denom_d = SW'(avs_writedata);
                  st_d = prs_st_run;
                  op_d = prs_op_sc1;
                  div_start = 1'b1;
                  div_x = MARGIN;
                  div_m = denom_d;
                  div_n = numer_d;
                end
                else
                  ev[`PRS_EV_SCL_REJ] = 1'b1;
              end
              `PRS_ADDR_REF, `PRS_ADDR_ACT, `PRS_ADDR_UPLIM,
              `PRS_ADDR_LOLIM, `PRS_ADDR_TGT, `PRS_ADDR_MEND:
              begin
                st_d = prs_st_run;
                div_start = 1'b1;
                case (avs_address)
                  `PRS_ADDR_REF:   op_d = prs_op_off;
                  `PRS_ADDR_ACT:   op_d = prs_op_setact;
                  `PRS_ADDR_UPLIM: op_d = prs_op_up;
                  `PRS_ADDR_LOLIM: op_d = prs_op_lo;
                  `PRS_ADDR_TGT:   op_d = prs_op_tgt;
                  default:
                  begin
                    // first find the actual in user units
                    op_d = prs_op_me1;
                    div_x = a_pos + off_q;
                    div_m = denom_q;
                    div_n = numer_q;
                  end
                endcase
              end
              `PRS_ADDR_STAT: clr_we = 1'b1;
              `PRS_ADDR_MASK: mask_we = 1'b1;
              default: ;
            endcase
          end
        end
      end
      prs_st_run:
      begin
        if (div_done)
        begin
          st_d = prs_st_done;
          case (op_q)
            prs_op_rd: rdata_d = 32'(q);
            // offset written or derived from a desired actual
            prs_op_off:    off_d = q;
            prs_op_setact: off_d = q - a_pos;
            prs_op_me1:
            begin
              act_d = q;
              // acceptance window for the mapping end
              if (in_rng(wdat_q, q + qs_q, q + qb_q) &&
                  in_rng(q, wdat_q - qb_q - TOL, wdat_q - qs_q + TOL))
              begin
                st_d = prs_st_run;
                op_d = prs_op_me2;
                div_start = 1'b1;
                div_x = wdat_q;
                div_m = numer_q;
                div_n = denom_q;
              end
              else
                ev[`PRS_EV_MEND_REJ] = 1'b1;
            end
            prs_op_me2:
            begin
              me_ok = 1'b1;
              me_d = rel;
              lo_d = rel - SPAN;
              hi_d = rel - MARGIN;
            end
            prs_op_up:
            begin
              if (in_rng(rel, lo_q, me_q - MARGIN))
                hi_d = rel;
              else
                ev[`PRS_EV_LIM_REJ] = 1'b1;
            end
            prs_op_lo:
            begin
              if (in_rng(rel, me_q - SPAN, hi_q))
                lo_d = rel;
              else
                ev[`PRS_EV_LIM_REJ] = 1'b1;
            end
            prs_op_tgt:
            begin
              // targets in a safety margin are refused
              if (in_rng(rel, lo_q, hi_q))
              begin
                // the drive follows the target in encoder sense
                tgt_d = dir_q ? -rel : rel;
                go_d = 1'b1;
                ev[`PRS_EV_TGT_OK] = 1'b1;
              end
              else
                ev[`PRS_EV_TGT_REJ] = 1'b1;
            end
            prs_op_sc1, prs_op_sc2:
            begin
              // bounds rounded to nearest by the divider
              st_d = prs_st_run;
              div_start = 1'b1;
              if (op_q == prs_op_sc1)
              begin
                qs_d = q;
                op_d = prs_op_sc2;
                div_x = SPAN;
              end
              else
              begin
                qb_d = q;
                op_d = prs_op_sc3;
                div_x = STEPS;
              end
            end
            prs_op_sc3: spr_d = q;
            default: ;
          endcase
        end
      end
      prs_st_done: st_d = prs_st_idle;
      default:     st_d = prs_st_idle;
    endcase
    wait_d = (st_d != prs_st_done);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= prs_st_idle;  op_q <= prs_op_rd;  rdata_q <= '0;  wait_q <= 1'b1;
      wdat_q <= '0;  dir_q <= 1'b0;
      numer_q <= `PRS_SCALE_DEF;  denom_q <= `PRS_SCALE_DEF;
      off_q <= OFF0;  me_q <= MEND0;  lo_q <= MEND0 - SPAN;  hi_q <= MEND0 - MARGIN;
      tgt_q <= '0;  act_q <= '0;  qs_q <= MARGIN;  qb_q <= SPAN;  spr_q <= STEPS;
      go_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;  op_q <= op_d;  rdata_q <= rdata_d;  wait_q <= wait_d;
      wdat_q <= wdat_d;  dir_q <= dir_d;  numer_q <= numer_d;  denom_q <= denom_d;
      off_q <= off_d;  me_q <= me_d;  lo_q <= lo_d;  hi_q <= hi_d;
      tgt_q <= tgt_d;  act_q <= act_d;  qs_q <= qs_d;  qb_q <= qb_d;  spr_q <= spr_d;
      go_q <= go_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign tgt_steps       = tgt_q;
  assign tgt_go          = go_q;

  prs_div #(.XW(PW), .MW(SW)) u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (div_start),
    .x        (div_x),
    .mul      (div_m),
    .den      (div_n),
    .done_q   (div_done),
    .quot_q   (div_q)
  );

  prs_irq #(.W(`PRS_EV_W)) u_irq (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ev       (ev),
    .clr_we   (clr_we),
    .mask_we  (mask_we),
    .wdata    (avs_writedata[`PRS_EV_W-1:0]),
    .stat_q   (stat),
    .mask_q   (mask),
    .irq_q    (irq)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic signed [47:0] e_spr, e_qs, e_qb, n48;
  assign n48   = 48'($signed({1'b0, numer_q}));
  assign e_spr = (48'(spr_q) * n48 - 48'(STEPS) * 48'($signed({1'b0, denom_q}))) <<< 1;
  assign e_qs  = (48'(qs_q) * n48 - 48'(MARGIN) * 48'($signed({1'b0, denom_q}))) <<< 1;
  assign e_qb  = (48'(qb_q) * n48 - 48'(SPAN) * 48'($signed({1'b0, denom_q}))) <<< 1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_spr; st_q != prs_st_run |-> e_spr <= n48 && e_spr >= -n48; endproperty
  a_spr: assert property (p_spr) else $error("steps per rotation off");
  property p_dflt; restore_now |=> numer_q == `PRS_SCALE_DEF && denom_q == `PRS_SCALE_DEF
    && me_q == MEND0 && off_q == OFF0; endproperty
  a_dflt: assert property (p_dflt) else $error("restore missed a default");
  property p_rng; scale_ok(32'(numer_q)) && scale_ok(32'(denom_q)); endproperty
  a_rng: assert property (p_rng) else $error("scale factor out of range");
  property p_win; me_ok |-> act_q >= wdat_q - qb_q - TOL && act_q <= wdat_q - qs_q + TOL;
  endproperty
  a_win: assert property (p_win) else $error("mapping end taken outside window");
  property p_qs; st_q != prs_st_run |-> e_qs <= n48 && e_qs >= -n48; endproperty
  a_qs: assert property (p_qs) else $error("minimum bound off");
  property p_qb; st_q != prs_st_run |-> e_qb <= n48 && e_qb >= -n48; endproperty
  a_qb: assert property (p_qb) else $error("maximum bound off");
  property p_lim; me_ok ##1 1'b1 |-> lo_q == me_q - SPAN && hi_q == me_q - MARGIN
    && $stable(numer_q); endproperty
  a_lim: assert property (p_lim) else $error("limits not recomputed");
  property p_span; hi_q <= me_q - MARGIN && lo_q >= me_q - SPAN && lo_q <= hi_q; endproperty
  a_span: assert property (p_span) else $error("limits outside span");
  property p_tgt; go_q |-> in_rng(dir_q ? -tgt_q : tgt_q, lo_q, hi_q)
    && $past(st_q) == prs_st_run; endproperty
  a_tgt: assert property (p_tgt) else $error("target in margin accepted");
  property p_ack; !wait_q |=> wait_q; endproperty
  a_ack: assert property (p_ack) else $error("waitrequest low two cycles");

  c_me:  cover property (me_ok);
  c_rej: cover property (ev[`PRS_EV_TGT_REJ]);
  c_scl: cover property (op_q == prs_op_sc3 && div_done);
endmodule

// File: tb/prs_ctl_model.sv
// Purpose: bus master model standing for the field controller
// Assumes: one request at a time; slave answers by dropping waitrequest
// Notes:   write data inverted after release so stale data is never trusted
`timescale 1ns/100ps
module prs_ctl_model
(
  input  wire logic        core_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        tgt_go,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  initial
  begin
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
  end
  // request held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic g);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    g = tgt_go;
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    avs_writedata <= ~d;
  endtask
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench of the position range block
// Assumes: one to one scaling until the scaling test
// Notes:   scaling expectations come from the bench's own rounding function
`timescale 1ns/100ps
`include "prs_cfg.svh"
module tb;
  logic               core_clk, nrst, avs_read, avs_write, avs_waitrequest, tgt_go, irq, g;
  logic        [5:0]  avs_address;
  logic        [31:0] avs_writedata, avs_readdata, q;
  logic        [3:0]  avs_byteenable;
  logic signed [31:0] enc_steps, tgt_steps;
  int                 num_errors, checks, n, d;
  logic        [5:0]  da[6] = '{`PRS_ADDR_NUMER, `PRS_ADDR_DENOM, `PRS_ADDR_STEPS,
                                `PRS_ADDR_MEND, `PRS_ADDR_LOLIM, `PRS_ADDR_UPLIM};
  int                 dv[6] = '{400, 400, 400, 102400, 1200, 101200};

  prs_top dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enc_steps(enc_steps), .tgt_steps(tgt_steps),
    .tgt_go(tgt_go), .irq(irq));
  prs_ctl_model ctl (.core_clk(core_clk), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tgt_go(tgt_go), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));

  // nearest integer, halves away from zero, a not negative
  function automatic logic [31:0] rnd(input int a, input int b);
    return 32'((2 * a + b) / (2 * b));
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task rd(input logic [5:0] a);
    ctl.xfer(1'b0, a, 32'h0, q, g);
  endtask
  task wr(input logic [5:0] a, input logic [31:0] v);
    ctl.xfer(1'b1, a, v, q, g);
  endtask
  task close_out;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out;
  end

  // -----------------------------
  // main sequence, configuration order kept
  // -----------------------------
  initial
  begin
    nrst = 1'b0;
    enc_steps = 32'sh0;
    num_errors = 0;
    checks = 0;
    void'($urandom(32'hfbab));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(da[i]);
      chk(q, 32'(dv[i]));
    end
    $display("test defaults done");
    wr(`PRS_ADDR_NUMER, 32'h0);
    wr(`PRS_ADDR_DENOM, 32'h2711);
    rd(`PRS_ADDR_NUMER);
    chk(q, 32'h190);
    rd(`PRS_ADDR_DENOM);
    chk(q, 32'h190);
    rd(`PRS_ADDR_STAT);
    chk(q & 32'h4, 32'h4);
    wr(`PRS_ADDR_MASK, 32'h4);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`PRS_ADDR_STAT, 32'h4);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test scale refusal done");
    enc_steps <= 32'sd51200;
    wr(`PRS_ADDR_MEND, 32'd52399);
    wr(`PRS_ADDR_MEND, 32'd152401);
    rd(`PRS_ADDR_MEND);
    chk(q, 32'd102400);
    rd(`PRS_ADDR_STAT);
    chk(q & 32'h1, 32'h1);
    wr(`PRS_ADDR_MEND, 32'd152400);
    rd(`PRS_ADDR_LOLIM);
    chk(q, 32'd51200);
    rd(`PRS_ADDR_UPLIM);
    chk(q, 32'd151200);
    wr(`PRS_ADDR_TGT, 32'd151201);
    chk({31'h0, g}, 32'h0);
    wr(`PRS_ADDR_TGT, 32'd151200);
    chk({31'h0, g}, 32'h1);
    chk(tgt_steps, 32'd151200);
    $display("test mapping end done");
    wr(`PRS_ADDR_ACT, 32'h0);
    rd(`PRS_ADDR_REF);
    chk(q, -32'sd51200);
    rd(`PRS_ADDR_MEND);
    chk(q, 32'd101200);
    wr(`PRS_ADDR_REF, 32'd1000);
    rd(`PRS_ADDR_ACT);
    chk(q, 32'd52200);
    wr(`PRS_ADDR_TGT, 32'd52200);
    chk(tgt_steps, 32'd51200);
    // limits now read 52200 and 152200; only narrowing is taken
    wr(`PRS_ADDR_UPLIM, 32'd152201);
    rd(`PRS_ADDR_STAT);
    chk(q & 32'h8, 32'h8);
    wr(`PRS_ADDR_LOLIM, 32'd60000);
    rd(`PRS_ADDR_LOLIM);
    chk(q, 32'd60000);
    rd(`PRS_ADDR_UPLIM);
    chk(q, 32'd152200);
    $display("test offset done");
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 0) ? 1 : $urandom_range(10000, 1);
      d = (k == 0) ? 10000 : $urandom_range(10000, 1);
      wr(`PRS_ADDR_NUMER, 32'(n));
      wr(`PRS_ADDR_DENOM, 32'(d));
      rd(`PRS_ADDR_STEPS);
      chk(q, rnd(400 * d, n));
      rd(`PRS_ADDR_ACT);
      chk(q, rnd(52200 * d, n));
    end
    $display("test scaling done");
    wr(`PRS_ADDR_CTRL, 32'h2);
    rd(`PRS_ADDR_STEPS);
    chk(q, 32'd400);
    rd(`PRS_ADDR_MEND);
    chk(q, 32'd102400);
    wr(`PRS_ADDR_CTRL, 32'h1);
    rd(`PRS_ADDR_CTRL);
    chk(q, 32'h1);
    rd(`PRS_ADDR_ACT);
    chk(q, -32'sd51200);
    wr(`PRS_ADDR_TGT, 32'd2000);
    chk({31'h0, g}, 32'h1);
    chk(tgt_steps, -32'sd2000);
    $display("test direction done");
    close_out;
  end
endmodule
